// *** inc/refgen_if.sv ***
`timescale 1ns/1ps
interface refgen_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport regs (input wr_en, input wr_data, output rd_data);
  modport bus (output wr_en, output wr_data, input rd_data);
endinterface

// *** inc/refgen_pkg.sv ***
package refgen_pkg;
  // Register index, not a byte offset: the bus byte address is four times it
  localparam logic [7:0] refgen_control_offset = 8'h9f;
  localparam logic [7:0] refgen_control_reset = 8'h00;
  localparam logic [7:0] refgen_control_mask = 8'hef;
  localparam int power_bit = 7;
  localparam int pin_drive_bit = 6;
  localparam int range_bit = 5;
  localparam int tap_msb = 3;
  localparam int tap_lsb = 0;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  // Ladder weights: low range code/24, high range 8/32 + code/32
  localparam int low_range_den = 24;
  localparam int high_range_den = 32;
  localparam int high_range_base = 8;
endpackage

// *** verification/refgen_top_tb.sv ***
`timescale 1ns/1ps
module refgen_top_tb;
  import refgen_pkg::*;
  // Register index times four gives the byte address
  localparam logic [31:0] reg_addr = {22'h0, refgen_control_offset, 2'b00};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dir;
  logic [31:0] awaddr, wdata, araddr, rd;
  logic [3:0] wstrb;
  logic [7:0] v;
  logic [1:0] resp;
  wire logic awready, wready, bvalid, arready, rvalid, pwr, drv, rng, conn;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] tap;
  int errors = 0;
  int n_tests = 0;
  refgen_top u_refgen_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .port_a_direction(dir), .ladder_power_on(pwr),
    .pin_drive_on(drv), .range_low_select(rng), .tap_code(tap),
    .port_a_bit2_pin_connect(conn));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Each bus task opens on a fresh edge so a released strobe is never raised in the same step
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask
  // Let the new level settle before relying on it; sample at the falling edge
  task automatic outs(input logic [7:0] e, input logic c);
    repeat (2) @(negedge aclk);
    chk("ladder", {24'h0, pwr, drv, rng, 1'b0, tap}, {24'h0, e & refgen_control_mask});
    chk("pin connect", {31'h0, conn}, {31'h0, c});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    #400us;
    errors++;
    results();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr, wstrb} = '0;
    dir = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(reg_addr);
    chk("reset value", rd, 32'h0);
    outs(8'h00, 1'b0);
    $display("reset test done");
    wr(reg_addr, 32'hffffffff, 4'hf);
    chk("write resp", {30'h0, resp}, {30'h0, resp_okay});
    rdr(reg_addr);
    chk("readback", rd, 32'hef);
    chk("read resp", {30'h0, resp}, {30'h0, resp_okay});
    outs(8'hff, 1'b1);
    @(posedge aclk);
    dir <= 1'b0;
    outs(8'hff, 1'b0);
    $display("access test done");
    for (int i = 0; i < 32; i++) begin
      v = {2'b10, i[4], 1'b0, i[3:0]};
      wr(reg_addr, {24'h0, v}, 4'h1);
      outs(v, 1'b0);
    end
    wr(reg_addr, 32'h0, 4'h0);
    chk("lane write resp", {30'h0, resp}, {30'h0, resp_okay});
    rdr(reg_addr);
    chk("lane hold", rd, {24'h0, v});
    outs(v, 1'b0);
    $display("tap test done");
    rdr(32'h40);
    chk("unmapped read resp", {30'h0, resp}, {30'h0, resp_slverr});
    chk("unmapped read data", rd, 32'h0);
    wr(32'h40, 32'h0, 4'hf);
    chk("unmapped write", {30'h0, resp}, {30'h0, resp_slverr});
    rdr(reg_addr);
    chk("after unmapped write", rd, {24'h0, v});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(reg_addr);
    chk("second reset", rd, 32'h0);
    outs(8'h00, 1'b0);
    $display("reset again test done");
    results();
  end
endmodule

// *** verilog/refgen_regs.sv ***
`timescale 1ns/1ps
module refgen_regs
  import refgen_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  refgen_if.regs rif,
  output logic [7:0] ctrl_q
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= refgen_control_reset;
    end else if (rif.wr_en) begin
      // Bit 4 is never stored, so it always reads zero
      ctrl_q <= rif.wr_data & refgen_control_mask;
    end
  end
  // No sleep input: wake events cannot touch the register
  assign rif.rd_data = ctrl_q;

  chk_reset_clears: assert property (@(posedge aclk)
    !aresetn |=> ctrl_q == refgen_control_reset)
    else $error("reset did not clear");
  chk_bit4_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q & ~refgen_control_mask) == 8'h00)
    else $error("bit 4 not zero");
  chk_hold_value: assert property (@(posedge aclk) disable iff (!aresetn)
    !rif.wr_en |=> $stable(ctrl_q))
    else $error("register changed without write");
endmodule

// *** verilog/refgen_top.sv ***
`timescale 1ns/1ps
module refgen_top
  import refgen_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port_a_direction,
  output logic ladder_power_on,
  output logic pin_drive_on,
  output logic range_low_select,
  output logic [3:0] tap_code,
  output logic port_a_bit2_pin_connect
);
  refgen_if rif();
  logic [7:0] ctrl_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic do_write;
  logic wr_hit;
  logic [7:0] ctrl_d;

  ////////////////////////////////////////////////////////////////////////
  // Write path: address and data taken in either order, one at a time
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit = awaddr_q[31:2] == 30'(refgen_control_offset);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // One write at a time: both halves are refused until the response is taken
  chk_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_aw_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_have_q |-> !s_axi_awready)
    else $error("second write address accepted");
  chk_w_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    w_have_q |-> !s_axi_wready)
    else $error("second write data accepted");
  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");
  chk_mapped_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && wr_hit |=> s_axi_bresp == resp_okay)
    else $error("register write not okay");
  chk_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && !wr_hit |=> s_axi_bresp == resp_slverr)
    else $error("unmapped write not refused");
  // Upper lanes carry nothing, so a write without lane 0 leaves the byte alone
  chk_lane_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && !wstrb_q[0] |=> $stable(ctrl_q))
    else $error("write without lane 0 changed register");

  // Register is a single byte; only lane 0 carries it
  assign rif.wr_en = do_write && wr_hit && wstrb_q[0];
  assign rif.wr_data = wdata_q[7:0];

  refgen_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(rif),
    .ctrl_q(ctrl_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[31:2] == 30'(refgen_control_offset)) begin
        s_axi_rdata <= {24'h000000, rif.rd_data};
        s_axi_rresp <= resp_okay;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= resp_slverr;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // A pending answer blocks the next address, so reads never overlap
  chk_read_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_read_value: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[31:2] == 30'(refgen_control_offset)
    |=> s_axi_rdata == {24'h000000, $past(ctrl_q)} && s_axi_rresp == resp_okay)
    else $error("register read wrong");
  chk_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[31:2] != 30'(refgen_control_offset)
    |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == resp_slverr)
    else $error("unmapped read not refused");
  chk_read_zeros: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata & ~{24'h000000, refgen_control_mask}) == 32'h00000000)
    else $error("unused read bits not zero");

  ////////////////////////////////////////////////////////////////////////
  // Ladder controls load the register's next value, so they move on the write edge
  // and still come straight from flops, with no decode glitches on the switches
  assign ctrl_d = rif.wr_en ? (rif.wr_data & refgen_control_mask) : ctrl_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ladder_power_on <= 1'b0;
      pin_drive_on <= 1'b0;
      range_low_select <= 1'b0;
      tap_code <= '0;
      port_a_bit2_pin_connect <= 1'b0;
    end else begin
      ladder_power_on <= ctrl_d[power_bit];
      pin_drive_on <= ctrl_d[pin_drive_bit];
      range_low_select <= ctrl_d[range_bit];
      tap_code <= ctrl_d[tap_msb:tap_lsb];
      // Driving the pin while it is an output would fight the port driver
      port_a_bit2_pin_connect <= ctrl_d[pin_drive_bit] && port_a_direction;
    end
  end

  chk_reset_outputs: assert property (@(posedge aclk)
    !aresetn |=> !ladder_power_on && !pin_drive_on && !range_low_select
      && tap_code == 4'h0 && !port_a_bit2_pin_connect)
    else $error("ladder outputs not cleared by reset");
  chk_power_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ladder_power_on == ctrl_q[power_bit])
    else $error("power differs from register");
  chk_drive_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_drive_on == ctrl_q[pin_drive_bit])
    else $error("drive differs from register");
  chk_range_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    range_low_select == ctrl_q[range_bit])
    else $error("range differs from register");
  chk_tap_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    tap_code == ctrl_q[tap_msb:tap_lsb])
    else $error("tap code differs from register");
  chk_pin_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    port_a_bit2_pin_connect |-> $past(port_a_direction) && pin_drive_on)
    else $error("pin connected while output");
  chk_pin_input: assert property (@(posedge aclk) disable iff (!aresetn)
    !port_a_direction |=> !port_a_bit2_pin_connect)
    else $error("pin still connected as output");
  chk_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    rif.wr_en |=> tap_code == $past(rif.wr_data[tap_msb:tap_lsb]))
    else $error("tap code not applied");
  chk_range_write: assert property (@(posedge aclk) disable iff (!aresetn)
    rif.wr_en |=> range_low_select == $past(rif.wr_data[range_bit]))
    else $error("range not applied");
endmodule
